// ===== rtl/uphy_pkg.sv
// Package: register map, field layout, reset values and carrier types of the USB PHY control bank
package uphy_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_UTMI_CONFIG = 16'hF008;
  localparam logic [15:0] IDX_RESET_CONTROL = 16'hF00A;
  localparam logic [15:0] IDX_SHIM_CONFIG = 16'hF00C;
  localparam logic [15:0] IDX_LINE_STATUS = 16'hF011;
  localparam int ADR_W = 18;
  localparam logic [17:0] ADDR_UTMI_CONFIG = {IDX_UTMI_CONFIG, 2'h0};
  localparam logic [17:0] ADDR_RESET_CONTROL = {IDX_RESET_CONTROL, 2'h0};
  localparam logic [17:0] ADDR_SHIM_CONFIG = {IDX_SHIM_CONFIG, 2'h0};
  localparam logic [17:0] ADDR_LINE_STATUS = {IDX_LINE_STATUS, 2'h0};

  // UTMI config field positions
  localparam int CFG_XTAL_LSB = 12;
  localparam int CFG_XTAL_MSB = 14;
  localparam int CFG_ID_PIN_BIT = 11;
  localparam int CFG_LPM_BIT = 10;
  localparam int CFG_PLL_BIT = 9;
  localparam int CFG_STUFF_BIT = 8;
  localparam int CFG_DM_PULLDOWN_BIT = 7;
  localparam int CFG_DP_PULLDOWN_BIT = 6;
  localparam int CFG_SUSPENDM_BIT = 5;
  localparam int CFG_OPMODE_LSB = 3;
  localparam int CFG_TERMSEL_BIT = 2;
  localparam int CFG_XCVR_LSB = 0;
  localparam int CFG_W = 15;

  // Reset control and shim field positions
  localparam int RST_UTMI_BIT = 1;
  localparam int RST_POR_RELEASE_BIT = 0;
  localparam int SHIM_FLAG_MODE_BIT = 1;
  localparam int SHIM_QUALIFY_BIT = 0;

  // Status field positions
  localparam int STAT_BIST_BIT = 4;
  localparam int STAT_ID_BIT = 3;
  localparam int STAT_DISC_BIT = 2;
  localparam int STAT_LS_LSB = 0;

  // Reset values and writable masks
  localparam logic [31:0] RST_UTMI_CONFIG = 32'h0000_102D;
  localparam logic [31:0] MASK_UTMI_CONFIG = 32'h0000_7FFF;
  localparam logic [31:0] RST_RESET_CONTROL = 32'h0000_0002;
  localparam logic [31:0] MASK_RESET_CONTROL = 32'h0000_0003;
  localparam logic [31:0] RST_SHIM_CONFIG = 32'h0000_0000;
  localparam logic [31:0] MASK_SHIM_CONFIG = 32'h0000_0003;

  // Pin input synchroniser
  localparam int SYNC_W = 7;

  typedef enum logic [2:0] {
    XTAL_10_MHZ = 3'h0,
    XTAL_12_MHZ = 3'h1,
    XTAL_25_MHZ = 3'h2,
    XTAL_30_MHZ = 3'h3,
    XTAL_19P2_MHZ = 3'h4,
    XTAL_24_MHZ = 3'h5,
    XTAL_27_MHZ = 3'h6,
    XTAL_40_MHZ = 3'h7
  } uphy_xtal_t;

  typedef enum logic [1:0] {
    LS_SE0 = 2'h0,
    LS_J = 2'h1,
    LS_K = 2'h2,
    LS_SE1 = 2'h3
  } uphy_line_state_t;

  // UTMI control outputs, laid out as config bits 14:0
  typedef struct packed {
    uphy_xtal_t crystal_freq_select;
    logic id_pin_detect_enable;
    logic link_power_mgmt_enable;
    logic phy_pll_enable;
    logic transmit_stuffing_enable;
    logic minus_line_pulldown;
    logic plus_line_pulldown;
    logic suspend_m;
    logic [1:0] op_mode;
    logic term_select;
    logic [1:0] xcvr_select;
  } uphy_utmi_ctrl_t;

  // PHY status inputs
  typedef struct packed {
    logic self_test_passed;
    logic id_pin_high_resistance;
    logic no_peripheral_attached;
    uphy_line_state_t line_state;
    logic rx_active;
    logic rx_valid;
  } uphy_phy_in_t;

endpackage

// ===== rtl/uphy_regs.sv
// USB PHY UTMI control, reset, receive shim and status registers on classic Wishbone
`timescale 1ns/1ps
module uphy_regs
  import uphy_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire uphy_phy_in_t PHY_STATUS_I,
  output uphy_utmi_ctrl_t UTMI_CTRL_O,
  output logic UTMI_RESET_O,
  output logic PHY_POWER_ON_RESET_RELEASE_O,
  output logic RX_FLAG0_O,
  output logic RX_FLAG1_O
);

  logic [31:0] utmi_config;
  logic [31:0] reset_control;
  logic [31:0] shim_config;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] phy_filt;
  uphy_phy_in_t phy_in;
  logic flag0;
  logic flag1;

  // Bus decode
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr = req & WB_WE_I;
  wire hit_cfg = (WB_ADR_I[ADR_W-1:2] == IDX_UTMI_CONFIG);
  wire hit_rst = (WB_ADR_I[ADR_W-1:2] == IDX_RESET_CONTROL);
  wire hit_shim = (WB_ADR_I[ADR_W-1:2] == IDX_SHIM_CONFIG);
  wire hit_stat = (WB_ADR_I[ADR_W-1:2] == IDX_LINE_STATUS);
  wire [31:0] lane_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // Byte-lane merge limited to writable bits
  wire [31:0] cfg_wmask = lane_mask & MASK_UTMI_CONFIG;
  wire [31:0] rst_wmask = lane_mask & MASK_RESET_CONTROL;
  wire [31:0] shim_wmask = lane_mask & MASK_SHIM_CONFIG;
  wire [31:0] next_utmi_config = (utmi_config & ~cfg_wmask) | (WB_DAT_I & cfg_wmask);
  wire [31:0] next_reset_control = (reset_control & ~rst_wmask) | (WB_DAT_I & rst_wmask);
  wire [31:0] next_shim_config = (shim_config & ~shim_wmask) | (WB_DAT_I & shim_wmask);

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      utmi_config <= RST_UTMI_CONFIG;
      reset_control <= RST_RESET_CONTROL;
      shim_config <= RST_SHIM_CONFIG;
    end else if (wr) begin
      if (hit_cfg) begin
        utmi_config <= next_utmi_config;
      end
      if (hit_rst) begin
        reset_control <= next_reset_control;
      end
      if (hit_shim) begin
        shim_config <= next_shim_config;
      end
    end
  end

  // Pin inputs: three synchroniser flops and a filter flop, a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          phy_filt[gi] <= 1'b0;
        end else begin
          sync1[gi] <= PHY_STATUS_I[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            phy_filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  assign phy_in = uphy_phy_in_t'(phy_filt);

  // Status word
  wire [31:0] status_word = {27'h0,
    phy_in.self_test_passed,
    phy_in.id_pin_high_resistance,
    phy_in.no_peripheral_attached,
    phy_in.line_state};

  // Read mux; unmapped addresses read zero
  wire [31:0] rd_data = hit_cfg ? utmi_config :
                        hit_rst ? reset_control :
                        hit_shim ? shim_config :
                        hit_stat ? status_word : 32'h0000_0000;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      if (req && !WB_WE_I) begin
        WB_DAT_O <= rd_data;
      end
    end
  end

  // Receive shim selection
  wire qualified_valid = shim_config[SHIM_QUALIFY_BIT] ?
                         (phy_in.rx_valid & phy_in.rx_active) : phy_in.rx_valid;
  wire next_flag0 = shim_config[SHIM_FLAG_MODE_BIT] ?
                    phy_in.line_state[0] : phy_in.rx_active;
  wire next_flag1 = shim_config[SHIM_FLAG_MODE_BIT] ?
                    phy_in.line_state[1] : qualified_valid;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flag0 <= 1'b0;
      flag1 <= 1'b0;
    end else begin
      flag0 <= next_flag0;
      flag1 <= next_flag1;
    end
  end

  assign RX_FLAG0_O = flag0;
  assign RX_FLAG1_O = flag1;
  assign UTMI_CTRL_O = uphy_utmi_ctrl_t'(utmi_config[CFG_W-1:0]);
  assign UTMI_RESET_O = reset_control[RST_UTMI_BIT];
  assign PHY_POWER_ON_RESET_RELEASE_O = reset_control[RST_POR_RELEASE_BIT];

endmodule // uphy_regs

// ===== tb/uphy_regs_asserts.sv
// Checker: register to pin properties of the PHY control bank
`timescale 1ns/1ps
module uphy_regs_asserts
  import uphy_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire uphy_phy_in_t PHY_STATUS_I,
  input wire uphy_utmi_ctrl_t UTMI_CTRL_O,
  input wire logic UTMI_RESET_O,
  input wire logic PHY_POWER_ON_RESET_RELEASE_O,
  input wire logic RX_FLAG0_O,
  input wire logic RX_FLAG1_O
);
  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);
  logic [1:0] shim;
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr0 = req & WB_WE_I & WB_SEL_I[0];
  wire rd = WB_ACK_O & ~WB_WE_I;
  wire is_cfg = WB_ADR_I == ADDR_UTMI_CONFIG;
  wire is_rst = WB_ADR_I == ADDR_RESET_CONTROL;
  wire is_stat = WB_ADR_I == ADDR_LINE_STATUS;
  wire phy_a = PHY_STATUS_I.rx_active;
  // Flag pair expected once pins and shim mode have been quiet
  wire [1:0] ef = shim[1] ? PHY_STATUS_I.line_state
    : {PHY_STATUS_I.rx_valid & (phy_a | ~shim[0]), phy_a};
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) shim <= 2'h0;
    else if (wr0 && WB_ADR_I == ADDR_SHIM_CONFIG) shim <= WB_DAT_I[1:0];
  end
  a_cfg_write: assert property (wr0 && WB_SEL_I == 4'hF && is_cfg
    |=> UTMI_CTRL_O == $past(WB_DAT_I[14:0])) else $error("cfg write");
  a_cfg_hold: assert property (!(req && WB_WE_I && is_cfg) |=> $stable(UTMI_CTRL_O))
    else $error("cfg changed");
  a_rst_write: assert property (wr0 && is_rst
    |=> {UTMI_RESET_O, PHY_POWER_ON_RESET_RELEASE_O} == $past(WB_DAT_I[1:0]))
    else $error("reset write");
  a_rsvd_zero: assert property (rd |-> WB_DAT_O[31:15] == 17'h0)
    else $error("reserved set");
  a_cfg_read: assert property (rd && is_cfg |-> WB_DAT_O[14:0] == UTMI_CTRL_O)
    else $error("cfg read");
  a_rst_read: assert property (rd && is_rst |-> WB_DAT_O ==
    {30'h0, UTMI_RESET_O, PHY_POWER_ON_RESET_RELEASE_O}) else $error("reset read");
  a_stat_rsvd: assert property (rd && is_stat |-> WB_DAT_O[31:5] == 27'h0)
    else $error("status read");
  a_flag_map: assert property ($stable({PHY_STATUS_I, shim})[*8]
    |-> {RX_FLAG1_O, RX_FLAG0_O} == ef) else $error("flag map");
  c_cfg: cover property (wr0 && is_cfg);
  c_stat: cover property (rd && is_stat);
  c_qual: cover property (shim == 2'h1 && phy_a == 1'b0 && PHY_STATUS_I.rx_valid);
endmodule // uphy_regs_asserts
bind uphy_regs uphy_regs_asserts u_chk (.*);

// ===== tb/uphy_phy_model.sv
// PHY model: status pins from commanded levels
`timescale 1ns/1ps
module uphy_phy_model
  import uphy_pkg::*;
(
  input wire uphy_phy_in_t cmd_i,
  input wire uphy_utmi_ctrl_t ctrl_i,
  input wire logic utmi_reset_i,
  input wire logic por_release_i,
  output uphy_phy_in_t status_o
);
  // Self test passes and pins 4:0 live only out of both resets; id pin gated by id_pin_detect_enable only
  wire live = por_release_i & ~utmi_reset_i;
  assign status_o = {live, cmd_i[5] & ctrl_i.id_pin_detect_enable, cmd_i[4:0] & {5{live}}};
endmodule // uphy_phy_model

// ===== tb/test_uphy_regs.sv
// Bench: register access, UTMI pins and receive flag shim
`timescale 1ns/1ps
module test_uphy_regs
  import uphy_pkg::*;
;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [17:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wd = '0, rdat, q;
  logic ack, ur, por, f0, f1;
  uphy_phy_in_t cmd = '0, st;
  uphy_utmi_ctrl_t ctrl;
  int n_mismatch = 0, tests_run = 0, cycles = 0;
  uphy_regs dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PHY_STATUS_I(st), .UTMI_CTRL_O(ctrl), .UTMI_RESET_O(ur),
    .PHY_POWER_ON_RESET_RELEASE_O(por), .RX_FLAG0_O(f0), .RX_FLAG1_O(f1));
  uphy_phy_model phy (.cmd_i(cmd), .ctrl_i(ctrl), .utmi_reset_i(ur), .por_release_i(por),
    .status_o(st));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wd} <= {2'h3, w, a, s, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  task rd(input logic [17:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_UTMI_CONFIG, RST_UTMI_CONFIG);
    chk(ctrl, RST_UTMI_CONFIG);
    rd(ADDR_RESET_CONTROL, RST_RESET_CONTROL);
    chk({ur, por}, 2'h2);
    rd(ADDR_SHIM_CONFIG, 32'h0);
    rd(ADDR_LINE_STATUS, 32'h0);
    for (int b = 0; b < 15; b++) begin
      wb(1'b1, ADDR_UTMI_CONFIG, 32'h1 << b, 4'hF);
      chk(ctrl, 32'h1 << b);
      rd(ADDR_UTMI_CONFIG, 32'h1 << b);
    end
    // Crystal codes, with reserved bits written high
    for (int x = 0; x < 8; x++) begin
      wb(1'b1, ADDR_UTMI_CONFIG, 32'hFFFF_8000 | (x << 12), 4'hF);
      chk(ctrl.crystal_freq_select, x);
      rd(ADDR_UTMI_CONFIG, x << 12);
    end
    wb(1'b1, ADDR_UTMI_CONFIG, 32'hFFFF_FFFF, 4'h1);
    rd(ADDR_UTMI_CONFIG, 32'h70FF);
    wb(1'b1, ADDR_LINE_STATUS, 32'h1F, 4'hF);
    wb(1'b1, 18'h0, 32'hFFFF_FFFF, 4'hF);
    rd(18'h0, 32'h0);
    wb(1'b1, ADDR_RESET_CONTROL, 32'hFFFF_FFFD, 4'hF);
    chk({ur, por}, 2'h1);
    rd(ADDR_RESET_CONTROL, 32'h1);
    wb(1'b1, ADDR_UTMI_CONFIG, 32'h1800, 4'hF);
    for (int i = 0; i < 8; i++) begin
      cmd <= {1'b0, i[0], i[2:0], 2'h0};
      repeat (8) @(posedge clk);
      rd(ADDR_LINE_STATUS, {27'h0, 1'b1, i[0], i[2:0]});
    end
    cmd <= 7'h09;
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, ADDR_SHIM_CONFIG, m, 4'hF);
      repeat (8) @(posedge clk);
      chk({f1, f0}, m[1] ? 2'h2 : {~m[0], 1'b0});
      rd(ADDR_SHIM_CONFIG, m);
    end
    wb(1'b1, ADDR_SHIM_CONFIG, 32'h1, 4'hF);
    cmd <= 7'h03;
    repeat (8) @(posedge clk);
    chk({f1, f0}, 2'h3);
    // Mid-run reset brings every register and flag back to its reset value
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_RESET_CONTROL, RST_RESET_CONTROL);
    chk({ur, por}, 2'h2);
    rd(ADDR_UTMI_CONFIG, RST_UTMI_CONFIG);
    rd(ADDR_SHIM_CONFIG, RST_SHIM_CONFIG);
    rd(ADDR_LINE_STATUS, 32'h0);
    chk({f1, f0}, 2'h0);
    finish_test;
  end
endmodule // test_uphy_regs
